// File: common/lcg_defs.svh
// Register offsets, field positions, reset values and sizes of the gating block
`ifndef LCG_DEFS_SVH
`define LCG_DEFS_SVH

// ****************************************
// Register byte offsets (one word each)
// ****************************************
`define LCG_OFS_CTRL 8'h00
`define LCG_OFS_POL 8'h04
`define LCG_OFS_SEL1 8'h08
`define LCG_OFS_SEL2 8'h0C
`define LCG_OFS_SEL3 8'h10
`define LCG_OFS_SEL4 8'h14
`define LCG_OFS_GLS0 8'h18

// ****************************************
// Field positions
// ****************************************
`define LCG_CTRL_EN_BIT 7
`define LCG_CTRL_OUT_BIT 5
`define LCG_POL_OUT_BIT 7
`define LCG_POL_GATE_MSB 3
`define LCG_SEL_W 6
`define LCG_NUM_DATA 4
`define LCG_NUM_GATES 4

// ****************************************
// Reset values
// ****************************************
`define LCG_CTRL_EN_RST 1'b0
`define LCG_POL_OUT_RST 1'b0
`define LCG_RD_UNMAPPED 8'h00

`endif

// File: common/lcg_pkg.sv
// Types shared by the gating block files
package lcg_pkg;

  // ****************************************
  // Register selection
  // ****************************************
  typedef enum logic [2:0] {
    LCG_REG_CTRL = 3'b000,
    LCG_REG_POL  = 3'b001,
    LCG_REG_SEL1 = 3'b010,
    LCG_REG_SEL2 = 3'b011,
    LCG_REG_SEL3 = 3'b100,
    LCG_REG_SEL4 = 3'b101,
    LCG_REG_GLS0 = 3'b110,
    LCG_REG_NONE = 3'b111
  } lcg_reg_e;

  typedef logic [7:0] lcg_byte_t;

endpackage

// File: core/lcg_sync.sv
// Two-flop synchroniser for a bus of independent level signals
`timescale 1ns/1ps
module lcg_sync #(
  parameter int W = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, synchronous levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// File: core/lcg_data_select.sv
// One data selector: picks a single source signal by its code
`timescale 1ns/1ps
module lcg_data_select #(
  parameter int SEL_W = 6
) (
  // Candidate sources, indexed by code
  input wire logic [(1<<SEL_W)-1:0] src_i,
  // Code of the chosen source
  input wire logic [SEL_W-1:0] code_i,
  // Chosen signal
  output logic data_o
);

  // Plain index; every code names a source, so none is illegal
  assign data_o = src_i[code_i];

endmodule

// File: core/lcg_input_gating.sv
// Input selection, gate 0 gating, polarity stages and registers of one logic cell
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lcg_defs.svh"

// Summary of operation
// - The cell output is inverted when the output invert bit is 1 and passed when it is 0.
// - Four gate invert bits in polarity bits 3..0 each invert their gate before the function.
// - Polarity bits 6..4 hold nothing and read as zero.
// - Four data select registers hold a 6-bit source code in bits 5..0 for data 1..4.
// - Bits 7..6 of each data select register hold nothing and read as zero.
// - Gate 0 enables pair per data input, bits 7/6 for data 4 down to bits 1/0 for data 1.
// - A set true-enable bit feeds the plain copy of its data input into gate 0.
// - A set negated-enable bit feeds the inverted copy of its data input into gate 0.
// - Reset clears the output invert and enable bits; gate inverts, selects and gate 0 enables keep their values.
// - The cell output after inversion is readable as a read-only control register bit.
// - With the enable bit clear the cell output is held at zero, otherwise it is formed.
module lcg_input_gating
  import lcg_pkg::*;
#(
  parameter int SEL_W = `LCG_SEL_W,
  parameter int NUM_SRC = 1 << `LCG_SEL_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Candidate input signals from pins and peripherals
  input wire logic [NUM_SRC-1:0] source_i,
  // Raw gates 1..3 from the neighbouring gating logic
  input wire logic [`LCG_NUM_GATES-1:1] gate_raw_upper_i,
  // Result of the logic function, before output inversion
  input wire logic func_result_i,
  // Towards the rest of the cell
  output logic [`LCG_NUM_DATA-1:0] selected_data_o,
  output logic [`LCG_NUM_GATES-1:0] gate_o,
  output logic cell_enable_o,
  output logic cell_result_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [NUM_SRC-1:0] src_sync;
  logic [`LCG_NUM_DATA-1:0] sel_data;
  logic [`LCG_NUM_DATA-1:0] sel_data_r;
  logic [SEL_W-1:0] data_source_r [`LCG_NUM_DATA];
  logic [7:0] gate0_en_r;
  logic [`LCG_POL_GATE_MSB:0] gate_invert_r;
  logic cell_output_invert_r;
  logic cell_enable_r;
  logic [`LCG_NUM_GATES-1:0] gate_r;
  logic cell_result_r;
  logic gate0_raw;
  logic ack_r;
  logic [31:0] rd_data_r;
  logic req;
  logic wr_en;
  lcg_reg_e reg_sel;
  logic pol_seen_r;

  // ****************************************
  // Helper functions
  // ****************************************

  // Word decode on the byte address; low two bits ignored
  function automatic lcg_reg_e decode(input logic [7:0] adr);
    logic [5:0] idx;
    idx = adr[7:2];
    if (idx == `LCG_OFS_CTRL >> 2) return LCG_REG_CTRL;
    if (idx == `LCG_OFS_POL >> 2) return LCG_REG_POL;
    if (idx == `LCG_OFS_SEL1 >> 2) return LCG_REG_SEL1;
    if (idx == `LCG_OFS_SEL2 >> 2) return LCG_REG_SEL2;
    if (idx == `LCG_OFS_SEL3 >> 2) return LCG_REG_SEL3;
    if (idx == `LCG_OFS_SEL4 >> 2) return LCG_REG_SEL4;
    if (idx == `LCG_OFS_GLS0 >> 2) return LCG_REG_GLS0;
    return LCG_REG_NONE;
  endfunction

  // Select register image, unused top bits forced low
  function automatic lcg_byte_t sel_image(input logic [SEL_W-1:0] code);
    lcg_byte_t img;
    img = '0;
    img[SEL_W-1:0] = code;
    return img;
  endfunction

  // ****************************************
  // Input synchronisation and data selection
  // ****************************************

  // Sources are asynchronous to clk_i
  lcg_sync #(
    .W(NUM_SRC)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(source_i),
    .sync_o(src_sync)
  );

  // One selector per data input
  for (genvar d = 0; d < `LCG_NUM_DATA; d++) begin : g_sel
    lcg_data_select #(
      .SEL_W(SEL_W)
    ) u_sel (
      .src_i(src_sync),
      .code_i(data_source_r[d]),
      .data_o(sel_data[d])
    );
  end

  // Registered so the selected data leaves from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_data_r <= '0;
    end else begin
      sel_data_r <= sel_data;
    end
  end

  // ****************************************
  // Gate 0 and polarity stages
  // ****************************************

  // Pair {true, negated} per data input, data 4 at the top
  always_comb begin
    gate0_raw = 1'b0;
    for (int d = 0; d < `LCG_NUM_DATA; d++) begin
      gate0_raw = gate0_raw | (gate0_en_r[2*d+1] & sel_data_r[d]);
      gate0_raw = gate0_raw | (gate0_en_r[2*d] & ~sel_data_r[d]);
    end
  end

  // Gate inversion before the logic function
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_r <= '0;
    end else begin
      gate_r <= {gate_raw_upper_i, gate0_raw} ^ gate_invert_r;
    end
  end

  // Disabled cell shows zero whatever the polarity bit says
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_result_r <= 1'b0;
    end else begin
      cell_result_r <= cell_enable_r & (func_result_i ^ cell_output_invert_r);
    end
  end

  // ****************************************
  // Wishbone handshake
  // ****************************************

  // Writes land at the same edge at which the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign reg_sel = decode(wb_adr_i);
  assign wr_en = req & wb_we_i & ack_r & wb_sel_i[0];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************

  // Enable cleared on every reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_enable_r <= `LCG_CTRL_EN_RST;
    end else if (wr_en && reg_sel == LCG_REG_CTRL) begin
      cell_enable_r <= wb_dat_i[`LCG_CTRL_EN_BIT];
    end
  end

  // Output invert cleared on every reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_output_invert_r <= `LCG_POL_OUT_RST;
    end else if (wr_en && reg_sel == LCG_REG_POL) begin
      cell_output_invert_r <= wb_dat_i[`LCG_POL_OUT_BIT];
    end
  end

  // Gate invert bits power up unknown, so the gate check waits for a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_seen_r <= 1'b0;
    end else if (wr_en && reg_sel == LCG_REG_POL) begin
      pol_seen_r <= 1'b1;
    end
  end

  // Selection and gating values survive a reset, unknown at power-up
  always_ff @(posedge clk_i) begin
    if (!rst_i && wr_en) begin
      unique case (reg_sel)
        LCG_REG_POL: gate_invert_r <= wb_dat_i[`LCG_POL_GATE_MSB:0];
        LCG_REG_SEL1: data_source_r[0] <= wb_dat_i[SEL_W-1:0];
        LCG_REG_SEL2: data_source_r[1] <= wb_dat_i[SEL_W-1:0];
        LCG_REG_SEL3: data_source_r[2] <= wb_dat_i[SEL_W-1:0];
        LCG_REG_SEL4: data_source_r[3] <= wb_dat_i[SEL_W-1:0];
        LCG_REG_GLS0: gate0_en_r <= wb_dat_i[7:0];
        LCG_REG_CTRL, LCG_REG_NONE: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Captured with ack; unmapped words read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= '0;
    end else if (req && !ack_r) begin
      rd_data_r <= '0;
      unique case (reg_sel)
        LCG_REG_CTRL: begin
          rd_data_r[`LCG_CTRL_EN_BIT] <= cell_enable_r;
          rd_data_r[`LCG_CTRL_OUT_BIT] <= cell_result_r;
        end
        LCG_REG_POL: begin
          rd_data_r[`LCG_POL_OUT_BIT] <= cell_output_invert_r;
          rd_data_r[`LCG_POL_GATE_MSB:0] <= gate_invert_r;
        end
        LCG_REG_SEL1: rd_data_r[7:0] <= sel_image(data_source_r[0]);
        LCG_REG_SEL2: rd_data_r[7:0] <= sel_image(data_source_r[1]);
        LCG_REG_SEL3: rd_data_r[7:0] <= sel_image(data_source_r[2]);
        LCG_REG_SEL4: rd_data_r[7:0] <= sel_image(data_source_r[3]);
        LCG_REG_GLS0: rd_data_r[7:0] <= gate0_en_r;
        LCG_REG_NONE: rd_data_r[7:0] <= `LCG_RD_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // All straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_data_r;
  assign selected_data_o = sel_data_r;
  assign gate_o = gate_r;
  assign cell_enable_o = cell_enable_r;
  assign cell_result_o = cell_result_r;

  // ****************************************
  // Assertions
  // ****************************************

  property p_out_polarity;
    @(posedge clk_i) disable iff (rst_i)
      $past(cell_enable_r) |-> cell_result_r == ($past(func_result_i) ^ $past(cell_output_invert_r));
  endproperty
  a_out_polarity: assert property (p_out_polarity)
    else $error("cell result does not follow output invert");

  property p_gate_polarity;
    @(posedge clk_i) disable iff (rst_i)
      pol_seen_r |=> gate_r[3:1] == ($past(gate_raw_upper_i) ^ $past(gate_invert_r[3:1]));
  endproperty
  a_gate_polarity: assert property (p_gate_polarity)
    else $error("upper gate inversion wrong");

  property p_pol_reserved;
    @(posedge clk_i) disable iff (rst_i)
      ack_r && !wb_we_i && reg_sel == LCG_REG_POL |-> wb_dat_o[6:4] == 3'h0;
  endproperty
  a_pol_reserved: assert property (p_pol_reserved)
    else $error("polarity reserved bits not zero");

  property p_sel_store;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && reg_sel == LCG_REG_SEL1 ##2 req && !wb_we_i && reg_sel == LCG_REG_SEL1 && !ack_r
      |=> wb_dat_o[SEL_W-1:0] == $past(wb_dat_i[SEL_W-1:0], 3);
  endproperty
  a_sel_store: assert property (p_sel_store)
    else $error("data 1 select readback mismatch");

  property p_sel_reserved;
    @(posedge clk_i) disable iff (rst_i)
      ack_r && !wb_we_i && (reg_sel inside {LCG_REG_SEL1, LCG_REG_SEL2, LCG_REG_SEL3,
        LCG_REG_SEL4}) |-> wb_dat_o[7:6] == 2'h0;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved)
    else $error("select reserved bits not zero");

  property p_g0_data4_true;
    @(posedge clk_i) disable iff (rst_i)
      gate0_en_r == 8'h80 |=> gate_r[0] == ($past(sel_data_r[3]) ^ $past(gate_invert_r[0]));
  endproperty
  a_g0_data4_true: assert property (p_g0_data4_true)
    else $error("gate 0 bit 7 does not pass data 4");

  property p_g0_true;
    @(posedge clk_i) disable iff (rst_i)
      gate0_en_r == 8'h02 && !gate_invert_r[0] |=> gate_r[0] == $past(sel_data_r[0]);
  endproperty
  a_g0_true: assert property (p_g0_true)
    else $error("gate 0 true copy of data 1 wrong");

  property p_g0_neg;
    @(posedge clk_i) disable iff (rst_i)
      gate0_en_r == 8'h01 && !gate_invert_r[0] |=> gate_r[0] == !$past(sel_data_r[0]);
  endproperty
  a_g0_neg: assert property (p_g0_neg)
    else $error("gate 0 inverted copy of data 1 wrong");

  property p_reset_keep;
    @(posedge clk_i)
      rst_i |=> !cell_output_invert_r && !cell_enable_r && $stable(gate0_en_r);
  endproperty
  a_reset_keep: assert property (p_reset_keep)
    else $error("reset handling of polarity or gating wrong");

  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
      ack_r && !wb_we_i && reg_sel == LCG_REG_CTRL |-> wb_dat_o[5] == $past(cell_result_r);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback bit differs from cell result");

  property p_disabled_zero;
    @(posedge clk_i) disable iff (rst_i)
      !cell_enable_r |=> !cell_result_r;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("disabled cell output not zero");

  property p_g0_empty;
    @(posedge clk_i) disable iff (rst_i)
      gate0_en_r == 8'h00 |=> gate_r[0] == $past(gate_invert_r[0]);
  endproperty
  a_g0_empty: assert property (p_g0_empty)
    else $error("empty gate 0 not zero before inversion");

endmodule

// File: verif/lcg_source_model.sv
// Model of the pin and peripheral signals offered to the data selectors
`timescale 1ns/1ps
module lcg_source_model (
  // Clock
  input wire logic clk_i,
  // Pattern request from the bench
  input wire logic load_i,
  input wire logic [63:0] pattern_i,
  // Candidate sources towards the cell
  output logic [63:0] src_o
);
  // Sources move only after an edge, then hold until the next request
  initial src_o = 64'h0;
  always @(posedge clk_i) begin
    if (load_i) begin
      src_o <= pattern_i;
    end
  end
endmodule

// File: verif/logic_cell_input_gating_bench.sv
// Self-checking bench of the cell input gating block
`timescale 1ns/1ps
`include "lcg_defs.svh"
module logic_cell_input_gating_bench import lcg_pkg::*;;
  logic clk, rst, cyc, stb, we, load, func, ack, en_o, res_o, en, r;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel, sdata, gate, d;
  logic [63:0] pattern, src;
  logic [2:0] upper;
  logic [5:0] code [4];
  lcg_byte_t v, gls, pv;
  integer seed = 40;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int k, i;

  // Clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  lcg_source_model lcg_source_model_inst (.clk_i(clk), .load_i(load), .pattern_i(pattern),
    .src_o(src));
  lcg_input_gating lcg_input_gating_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .source_i(src), .gate_raw_upper_i(upper),
    .func_result_i(func), .selected_data_o(sdata), .gate_o(gate), .cell_enable_o(en_o),
    .cell_result_o(res_o));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One classic cycle; ack is sampled before this edge's updates land
  task automatic xfer(input logic w, input lcg_byte_t a, input lcg_byte_t dv,
                      input logic [3:0] s, output logic [31:0] rq);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, dv};
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    check("ack latency", 32'(n), 32'h2);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    check("ack drop", 32'(ack), 32'h0);
  endtask

  task automatic wr(input lcg_byte_t a, input lcg_byte_t dv);
    logic [31:0] dummy;
    xfer(1'b1, a, dv, 4'hF, dummy);
  endtask

  task automatic rd_chk(input string what, input lcg_byte_t a, input lcg_byte_t exp);
    logic [31:0] rq;
    xfer(1'b0, a, 8'h00, 4'hF, rq);
    check(what, rq, {24'h0, exp});
  endtask

  // Gate 0 is the OR of the enabled copies, then its own inversion
  function automatic logic exp_gate0(input lcg_byte_t g, input logic [3:0] dd, input logic inv);
    logic acc;
    acc = 1'b0;
    for (int j = 0; j < 4; j++) begin
      acc = acc | (g[2*j+1] & dd[j]) | (g[2*j] & ~dd[j]);
    end
    return acc ^ inv;
  endfunction

  // Hang guard, well above the about 1730 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {cyc, stb, we, load, func} = 5'h00;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    pattern = 64'h0;
    upper = 3'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl reset", `LCG_OFS_CTRL, 8'h00);
    xfer(1'b0, `LCG_OFS_POL, 8'h00, 4'hF, q);
    check("pol reset", q & 32'hFFFF_FFF0, 32'h0);
    check("result reset", 32'(res_o), 32'h0);
    // Access masks of the polarity, select and gate 0 registers
    for (k = 0; k < 12; k++) begin
      v = 8'($random(seed));
      wr(`LCG_OFS_POL, v);
      rd_chk("pol", `LCG_OFS_POL, v & 8'h8F);
      for (i = 0; i < 4; i++) begin
        wr(`LCG_OFS_SEL1 + 8'(4 * i), v ^ 8'(i));
        rd_chk("select", `LCG_OFS_SEL1 + 8'(4 * i), (v ^ 8'(i)) & 8'h3F);
      end
      wr(`LCG_OFS_GLS0, v);
      rd_chk("gls0", `LCG_OFS_GLS0, v);
    end
    // Lane 0 off and unmapped words leave registers alone
    wr(`LCG_OFS_GLS0, 8'h5A);
    xfer(1'b1, `LCG_OFS_GLS0, 8'hA5, 4'hE, q);
    wr(8'h1C, 8'hFF);
    rd_chk("unmapped", 8'h1C, 8'h00);
    rd_chk("gls0 kept", `LCG_OFS_GLS0, 8'h5A);
    // Mid-run reset clears the output invert but keeps gate inverts, select and gate 0 enables
    wr(`LCG_OFS_POL, 8'h85);
    wr(`LCG_OFS_SEL3, 8'h2B);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_chk("pol retained", `LCG_OFS_POL, 8'h05);
    rd_chk("select retained", `LCG_OFS_SEL3, 8'h2B);
    rd_chk("gls0 retained", `LCG_OFS_GLS0, 8'h5A);
    // Single enables, the empty gate, then random mixes
    for (k = 0; k < 40; k++) begin
      gls = (k < 8) ? (8'h01 << k) : ((k == 8) ? 8'h00 : 8'($random(seed)));
      pv = 8'($random(seed));
      for (i = 0; i < 4; i++) begin
        code[i] = 6'($random(seed));
        wr(`LCG_OFS_SEL1 + 8'(4 * i), {2'b00, code[i]});
      end
      wr(`LCG_OFS_GLS0, gls);
      wr(`LCG_OFS_POL, pv);
      en = 1'($random(seed));
      wr(`LCG_OFS_CTRL, {en, 7'($random(seed))});
      pattern <= {$random(seed), $random(seed)};
      upper <= 3'($random(seed));
      func <= 1'($random(seed));
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      repeat (6) @(posedge clk);
      for (i = 0; i < 4; i++) begin
        d[i] = pattern[code[i]];
      end
      r = en & (func ^ pv[7]);
      check("data", 32'(sdata), 32'(d));
      check("gates", 32'(gate), 32'({upper ^ pv[3:1], exp_gate0(gls, d, pv[0])}));
      check("enable", 32'(en_o), 32'(en));
      check("result", 32'(res_o), 32'(r));
      rd_chk("ctrl", `LCG_OFS_CTRL, {en, 1'b0, r, 5'h00});
    end
    summarize();
  end
endmodule
